// >>> verilog/sfp_pkg.sv
// constants and types for the sector flash program controller
// assumes a 40 MHz aclk and one parallel flash on the pins
package sfp_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    localparam int SECTOR_LSB = 8;
    localparam int SECTOR_W = ADDR_W - SECTOR_LSB;
    localparam int CNT_W = 24;
    localparam int AXI_AW = 8;

    localparam longint CLK_PERIOD_PS = 25000;
    localparam longint PS_PER_NS = 1000;
    // inter-byte window, longest time: round down
    localparam longint LOAD_GAP_US = 150;
    localparam int LOAD_GAP_CYCLES = int'(LOAD_GAP_US * 1000 * PS_PER_NS / CLK_PERIOD_PS);
    // power-on lockout, least time: round up
    localparam longint POR_DELAY_MS = 5;
    localparam int POR_CYCLES =
        int'((POR_DELAY_MS * 1000000 * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    // slowest access grade, least time: round up
    localparam longint ACC_TIME_NS = 150;
    localparam int SYNC_STAGES = 2;
    localparam int RD_CYCLES =
        int'((ACC_TIME_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) + SYNC_STAGES;
    localparam longint FLOAT_TIME_NS = 40;
    localparam int DF_CYCLES = int'((FLOAT_TIME_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    // strobe width well above the noise filter
    localparam longint WE_PULSE_NS = 100;
    localparam int WP_CYCLES = int'((WE_PULSE_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    // margin so the next falling edge lands inside the window
    localparam int WIN_GUARD = 4;

    localparam logic [AXI_AW-1:0] REG_CMD = 8'h00;
    localparam logic [AXI_AW-1:0] REG_ADDR = 8'h04;
    localparam logic [AXI_AW-1:0] REG_WDATA = 8'h08;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h0C;
    localparam logic [AXI_AW-1:0] REG_RDATA = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;

    localparam int CMD_READ_BIT = 0;
    localparam int CMD_LOAD_BIT = 1;
    localparam int CMD_POLL_BIT = 2;

    localparam int ST_BUSY = 0;
    localparam int ST_WIN = 1;
    localparam int ST_RUN = 2;
    localparam int ST_POLL_DONE = 3;
    localparam int ST_POR_DONE = 4;
    localparam int ST_SEC_ERR = 5;
    localparam int ST_REFUSED = 6;

    localparam int POLL_BIT = 7;
    localparam int TOGGLE_STATUS_BIT = 6;

    // boot region check locations and answers in identification mode
    localparam logic [ADDR_W-1:0] LOW_BOOT_CHECK = 18'h00002;
    localparam logic [ADDR_W-1:0] HIGH_BOOT_CHECK = 18'h3FFF2;
    localparam logic [DATA_W-1:0] BOOT_OPEN = 8'hFE;
    localparam logic [DATA_W-1:0] BOOT_LOCKED = 8'hFF;

    typedef logic [CNT_W-1:0] sfp_cnt_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_RD_SETUP = 3'b001,
        S_RD_WAIT = 3'b010,
        S_TURN = 3'b011,
        S_WR_SETUP = 3'b100,
        S_WR_PULSE = 3'b101,
        S_WR_HOLD = 3'b110
    } sfp_state_t;
endpackage : sfp_pkg

// >>> verilog/sfp_host.sv
// host controller driving a parallel sector flash through its pins
// assumes software on AXI4-Lite; flash data pins arrive asynchronous
`timescale 1ns/1ps

// Behaviour
// RQ1 - never drive data while flash outputs enabled
// RQ2 - byte load: write strobe pulse, select low
// RQ3 - software loads every byte of the sector; the bench loads only three bytes
// RQ4 - next falling strobe within the load window
// RQ5 - idle window closes load, programming assumed
// RQ6 - sector address constant across one load
// RQ7 - low address bits pick byte, any order
// RQ8 - program cycle awaited by polling
// RQ9 - reads during cycle are status polls
// RQ10 - guard enable sent as plain byte loads
// RQ11 - guard prefix sent as plain byte loads
// RQ12 - guard persists, host keeps no copy
// RQ13 - unprefixed write still needs polling
// RQ14 - strobe only with output drive high
// RQ15 - strobe pulses far longer than filter
// RQ16 - no write before power-on delay
// RQ17 - poll bit compared to loaded value
// RQ18 - toggle bit must stop between reads
// RQ19 - identification reads are plain reads
// RQ20 - locked boot regions ignore loads
// RQ21 - lock sequences sent as plain loads
// RQ22 - boot check reads return open or locked
// RQ23 - no loads while program cycle runs
module sfp_host
    import sfp_pkg::*;
#(
    parameter int unsigned WIN_CYC = LOAD_GAP_CYCLES,
    parameter int unsigned POR_CYC = POR_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [ADDR_W-1:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [DATA_W-1:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [DATA_W-1:0] flash_dq_i
);
    typedef struct packed {
        sfp_state_t st;
        logic [7:0] cnt;
        sfp_cnt_t gap;
        sfp_cnt_t por;
        logic por_done;
        logic win_open;
        logic running;
        logic poll_mode;
        logic have_prev;
        logic poll_done;
        logic sec_err;
        logic refused;
        logic [SECTOR_W-1:0] sector;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] last_addr;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] last_data;
        logic [DATA_W-1:0] prev;
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] dq_o;
        logic [DATA_W-1:0] s1;
        logic [DATA_W-1:0] s2;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe;
        logic aw_got;
        logic w_got;
        logic bvalid;
        logic rvalid;
        logic [AXI_AW-1:0] aw_addr;
        logic [31:0] w_data;
        logic w_lane0;
        logic [31:0] rd;
    } sfp_regs_t;

    sfp_regs_t r_reg;
    sfp_regs_t r_next;
    logic [31:0] status;
    logic do_wr;
    logic wr_cmd;

    assign s_axi_awready = !r_reg.aw_got && !r_reg.bvalid;
    assign s_axi_wready = !r_reg.w_got && !r_reg.bvalid;
    assign s_axi_arready = !r_reg.rvalid;
    assign s_axi_bvalid = r_reg.bvalid;
    assign s_axi_bresp = RESP_OKAY;
    assign s_axi_rvalid = r_reg.rvalid;
    assign s_axi_rresp = RESP_OKAY;
    assign s_axi_rdata = r_reg.rd;
    assign flash_addr = r_reg.a;
    assign flash_ce_n = r_reg.ce_n;
    assign flash_oe_n = r_reg.oe_n;
    assign flash_we_n = r_reg.we_n;
    assign flash_dq_o = r_reg.dq_o;
    assign flash_dq_oe = r_reg.dq_oe;

    always_comb begin
        status = 32'h0;
        status[ST_BUSY] = r_reg.st != S_IDLE;
        status[ST_WIN] = r_reg.win_open;
        status[ST_RUN] = r_reg.running;
        status[ST_POLL_DONE] = r_reg.poll_done;
        status[ST_POR_DONE] = r_reg.por_done;
        status[ST_SEC_ERR] = r_reg.sec_err;
        status[ST_REFUSED] = r_reg.refused;
        do_wr = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;
        wr_cmd = do_wr && r_reg.w_lane0 && r_reg.aw_addr == REG_CMD;
    end

    always_comb begin
        r_next = r_reg;
        r_next.s1 = flash_dq_i;
        r_next.s2 = r_reg.s1;
        if (s_axi_awvalid && s_axi_awready) begin
            r_next.aw_got = 1'b1;
            r_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            r_next.w_got = 1'b1;
            r_next.w_data = s_axi_wdata;
            r_next.w_lane0 = s_axi_wstrb[0];
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            r_next.rvalid = 1'b1;
            case (s_axi_araddr)
                REG_ADDR: r_next.rd = {14'h0, r_reg.addr};
                REG_WDATA: r_next.rd = {24'h0, r_reg.wdata};
                REG_STATUS: r_next.rd = status;
                // boot check reads land here as open or locked codes
                REG_RDATA: r_next.rd = {24'h0, r_reg.rdata}; // RQ22
                default: r_next.rd = 32'h0;
            endcase
        end
        if (do_wr) begin
            r_next.aw_got = 1'b0;
            r_next.w_got = 1'b0;
            r_next.bvalid = 1'b1;
            if (r_reg.w_lane0) begin
                case (r_reg.aw_addr)
                    REG_ADDR: r_next.addr = r_reg.w_data[ADDR_W-1:0];
                    REG_WDATA: r_next.wdata = r_reg.w_data[DATA_W-1:0];
                    REG_STATUS: begin
                        if (r_reg.w_data[ST_SEC_ERR]) begin
                            r_next.sec_err = 1'b0;
                        end
                        if (r_reg.w_data[ST_REFUSED]) begin
                            r_next.refused = 1'b0;
                        end
                        if (r_reg.w_data[ST_POLL_DONE]) begin
                            r_next.poll_done = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        // power-on lockout counter
        if (!r_reg.por_done) begin
            r_next.por = r_reg.por + 1'b1;
            if (r_reg.por == sfp_cnt_t'(POR_CYC - 1)) begin
                r_next.por_done = 1'b1; // RQ16
            end
        end
        // idle gap after the last rising strobe ends the load
        if (r_reg.win_open) begin
            r_next.gap = r_reg.gap + 1'b1;
            if (r_reg.st == S_IDLE && r_reg.gap >= sfp_cnt_t'(WIN_CYC - WIN_GUARD)) begin
                r_next.win_open = 1'b0;
                r_next.running = 1'b1; // RQ5
            end
        end
        if (wr_cmd && r_reg.st != S_IDLE && r_reg.w_data[2:0] != 3'h0) begin
            r_next.refused = 1'b1;
        end
        case (r_reg.st)
            S_IDLE: begin
                if (wr_cmd && r_reg.w_data[CMD_LOAD_BIT]) begin
                    // window closing this cycle counts as running already
                    if (!r_reg.por_done || r_next.running) begin
                        r_next.refused = 1'b1; // RQ23
                    end else if (r_reg.win_open
                                 && r_reg.addr[ADDR_W-1:SECTOR_LSB] != r_reg.sector) begin
                        r_next.sec_err = 1'b1; // RQ6
                    end else begin
                        // prefix, lock and data bytes all go out the same way
                        r_next.sector = r_reg.addr[ADDR_W-1:SECTOR_LSB]; // RQ11 RQ21
                        r_next.last_addr = r_reg.addr; // RQ7
                        r_next.last_data = r_reg.wdata;
                        r_next.st = S_WR_SETUP;
                    end
                end else if (wr_cmd && r_reg.w_data[CMD_READ_BIT]) begin
                    if (r_reg.win_open) begin
                        r_next.refused = 1'b1;
                    end else begin
                        r_next.poll_mode = 1'b0;
                        r_next.st = S_RD_SETUP;
                    end
                end else if (wr_cmd && r_reg.w_data[CMD_POLL_BIT]) begin
                    if (r_reg.win_open) begin
                        r_next.refused = 1'b1;
                    end else begin
                        r_next.poll_mode = 1'b1; // RQ8
                        r_next.have_prev = 1'b0;
                        r_next.poll_done = 1'b0;
                        r_next.st = S_RD_SETUP;
                    end
                end
            end
            S_RD_SETUP: begin
                r_next.a = r_reg.poll_mode ? r_reg.last_addr : r_reg.addr;
                r_next.ce_n = 1'b0;
                r_next.oe_n = 1'b0;
                r_next.cnt = 8'(RD_CYCLES);
                r_next.st = S_RD_WAIT;
            end
            S_RD_WAIT: begin
                if (r_reg.cnt != 8'h0) begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end else begin
                    r_next.rdata = r_reg.s2;
                    r_next.ce_n = 1'b1;
                    r_next.oe_n = 1'b1;
                    r_next.cnt = 8'(DF_CYCLES);
                    r_next.st = S_TURN;
                    if (r_reg.poll_mode) begin
                        r_next.prev = r_reg.s2;
                        r_next.have_prev = 1'b1;
                        // true data once both status bits settle
                        if (r_reg.have_prev
                            && r_reg.s2[TOGGLE_STATUS_BIT] == r_reg.prev[TOGGLE_STATUS_BIT]
                            && r_reg.s2[POLL_BIT] == r_reg.last_data[POLL_BIT]) begin
                            r_next.poll_mode = 1'b0; // RQ17 RQ18
                            r_next.poll_done = 1'b1;
                            r_next.running = 1'b0; // RQ9
                        end
                    end
                end
            end
            S_TURN: begin
                if (r_reg.cnt != 8'h0) begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end else begin
                    r_next.st = r_reg.poll_mode ? S_RD_SETUP : S_IDLE;
                end
            end
            S_WR_SETUP: begin
                r_next.a = r_reg.addr; // RQ3
                r_next.dq_o = r_reg.wdata;
                r_next.dq_oe = 1'b1;
                r_next.ce_n = 1'b0;
                r_next.oe_n = 1'b1; // RQ14
                r_next.cnt = 8'(WP_CYCLES - 1);
                r_next.st = S_WR_PULSE;
            end
            S_WR_PULSE: begin
                if (r_reg.we_n) begin
                    r_next.we_n = 1'b0; // RQ2
                end else if (r_reg.cnt != 8'h0) begin
                    r_next.cnt = r_reg.cnt - 1'b1; // RQ15
                end else begin
                    r_next.we_n = 1'b1;
                    r_next.st = S_WR_HOLD;
                end
            end
            S_WR_HOLD: begin
                r_next.dq_oe = 1'b0;
                r_next.ce_n = 1'b1;
                r_next.gap = '0; // RQ4
                r_next.win_open = 1'b1;
                r_next.st = S_IDLE;
            end
            default: r_next.st = S_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
            r_reg.ce_n <= 1'b1;
            r_reg.oe_n <= 1'b1;
            r_reg.we_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_no_contention;
        !flash_oe_n |-> !flash_dq_oe;
    endproperty
    a_no_contention: assert property (p_no_contention) // RQ1
        else $error("data driven while flash outputs enabled");

    property p_load_mode;
        !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe;
    endproperty
    a_load_mode: assert property (p_load_mode) // RQ2
        else $error("write strobe low outside byte load mode");

    property p_strobe_width;
        $fell(flash_we_n) |-> (!flash_we_n && $stable(flash_dq_o) && $stable(flash_addr))[*4];
    endproperty
    a_strobe_width: assert property (p_strobe_width) // RQ15
        else $error("write strobe pulse short or data moved");

    property p_gap;
        $fell(flash_we_n) && r_reg.win_open |-> r_reg.gap < sfp_cnt_t'(WIN_CYC);
    endproperty
    a_gap: assert property (p_gap) // RQ4
        else $error("next byte started after load window");

    property p_sector;
        $fell(flash_we_n) |-> flash_addr[ADDR_W-1:SECTOR_LSB] == r_reg.sector;
    endproperty
    a_sector: assert property (p_sector) // RQ6
        else $error("sector address changed within load");

    property p_no_write_running;
        r_reg.running |-> flash_we_n;
    endproperty
    a_no_write_running: assert property (p_no_write_running) // RQ23
        else $error("write strobe during program cycle");

    property p_por;
        !r_reg.por_done |-> flash_we_n;
    endproperty
    a_por: assert property (p_por) // RQ16
        else $error("write before power-on delay elapsed");

    property p_close;
        r_reg.win_open && r_reg.st == S_IDLE && r_reg.gap == sfp_cnt_t'(WIN_CYC - WIN_GUARD)
            |=> r_reg.running && !r_reg.win_open;
    endproperty
    a_close: assert property (p_close) // RQ5
        else $error("load window did not close on time");

    property p_poll_end;
        $rose(r_reg.poll_done) |-> r_reg.rdata[POLL_BIT] == r_reg.last_data[POLL_BIT]
            && !r_reg.running;
    endproperty
    a_poll_end: assert property (p_poll_end) // RQ17
        else $error("poll ended without true data bit");
endmodule : sfp_host

// >>> bench/sfp_flash_model.sv
// behavioural parallel sector flash standing on the host controller's pins
// assumes loads strobed by write enable under chip select, one host driver
`timescale 1ns/1ps
module sfp_flash_model #(
    parameter int GAP_NS = 800,
    parameter int PROG_NS = 5000
) (
    input wire logic [17:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out
);
    logic [7:0] mem [logic [17:0]];
    logic [7:0] page [logic [7:0]];
    logic [17:0] lat_a = '0;
    logic [9:0] sec = '0;
    logic [7:0] last_d = 8'h00;
    logic [7:0] last_out = 8'h00;
    logic loading = 1'b0;
    logic prog_active = 1'b0;
    logic tog = 1'b0;
    time fall_t = 0;
    time rise_t = 0;
    time end_t = 0;

    always @(negedge we_n) begin
        fall_t = $time;
        lat_a = addr;
    end

    always @(posedge we_n) begin
        if (!ce_n && oe_n && !prog_active && ($time - fall_t) >= 15) begin
            page[lat_a[7:0]] = dq_in;
            sec = lat_a[17:8];
            last_d = dq_in;
            // guard off as delivered: a plain load also starts the timer
            loading = 1'b1;
            rise_t = $time;
        end
    end

    // load window, then erase and write of the whole sector
    always #25 begin
        if (loading && we_n && ($time - rise_t) >= GAP_NS) begin
            loading = 1'b0;
            prog_active = 1'b1;
            end_t = $time + PROG_NS;
        end
        if (prog_active && $time >= end_t) begin
            for (int i = 0; i < 256; i++) begin
                mem.delete({sec, i[7:0]});
            end
            foreach (page[k]) begin
                mem[{sec, k}] = page[k];
            end
            page.delete();
            prog_active = 1'b0;
        end
    end

    always @(negedge oe_n) begin
        if (!ce_n && prog_active) begin
            tog = ~tog;
        end
    end

    always @(ce_n, oe_n, we_n, addr, prog_active, tog) begin
        if (!ce_n && !oe_n && we_n) begin
            if (prog_active) begin
                dq_out = {~last_d[7], tog, last_d[5:0]};
            end else begin
                dq_out = mem.exists(addr) ? mem[addr] : 8'hFF;
            end
            last_out = dq_out;
        end else begin
            // released bus shows no stale value
            dq_out = ~last_out;
        end
    end
endmodule : sfp_flash_model

// >>> bench/sfp_host_tb.sv
// self-checking bench for the sector flash host controller
// assumes the behavioural flash model on the pins, AXI4-Lite on the host side
`timescale 1ns/1ps
module sfp_host_tb
    import sfp_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [AXI_AW-1:0] awaddr = '0;
    logic [AXI_AW-1:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, dq_oe;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [ADDR_W-1:0] f_addr;
    logic [DATA_W-1:0] dq_o, dq_i, mdl_dq;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;

    assign dq_i = dq_oe ? dq_o : mdl_dq;

    sfp_host #(.WIN_CYC(40), .POR_CYC(20)) sfp_host_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .flash_addr(f_addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i));

    // window of 40 host cycles, so the host's guard closes first
    sfp_flash_model #(.GAP_NS(1000), .PROG_NS(5000)) sfp_flash_model_i (
        .addr(f_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_in(dq_i),
        .dq_out(mdl_dq));

    always #12.5 aclk = ~aclk;

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // handshake seen before each edge, released just after it
    task automatic axw(input logic [AXI_AW-1:0] a, input logic [31:0] d);
        logic aw, w, b;
        b = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b) begin
            @(negedge aclk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid && bready;
            @(posedge aclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
    endtask : axw

    task automatic axr(input logic [AXI_AW-1:0] a, output logic [31:0] d);
        logic ar, r;
        r = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r) begin
            @(negedge aclk);
            ar = arvalid && arready;
            r = rvalid && rready;
            d = rdata;
            @(posedge aclk);
            if (ar) arvalid <= 1'b0;
        end
    endtask : axr

    task automatic rchk(input logic [AXI_AW-1:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        axr(a, d);
        chk(d, exp, what);
    endtask : rchk

    task automatic wst(input int b, input logic v);
        logic [31:0] d;
        axr(REG_STATUS, d);
        while (d[b] !== v) begin
            axr(REG_STATUS, d);
        end
    endtask : wst

    task automatic load(input logic [17:0] a, input logic [7:0] d);
        axw(REG_ADDR, {14'h0, a});
        axw(REG_WDATA, {24'h0, d});
        axw(REG_CMD, 32'h2);
        wst(ST_BUSY, 1'b0);
    endtask : load

    task automatic fread(input logic [17:0] a, input logic [7:0] exp);
        axw(REG_ADDR, {14'h0, a});
        axw(REG_CMD, 32'h1);
        wst(ST_BUSY, 1'b0);
        rchk(REG_RDATA, {24'h0, exp}, "flash read data");
    endtask : fread

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(REG_STATUS, 32'h0, "status after reset");
        axw(REG_CMD, 32'h2);
        rchk(REG_STATUS, 32'h40, "early load refused");
        axw(REG_STATUS, 32'h40);
        repeat (20) @(posedge aclk);
        rchk(REG_STATUS, 32'h10, "power-on delay over");
        axw(8'h20, 32'hFFFFFFFF);
        rchk(8'h20, 32'h0, "unmapped read");
        wstrb <= 4'hE;
        axw(REG_ADDR, 32'h3FFFF);
        wstrb <= 4'hF;
        rchk(REG_ADDR, 32'h0, "write without low lane");
        load(18'h01205, 8'hA5);
        load(18'h01202, 8'h3C);
        load(18'h012FF, 8'h81);
        axw(REG_ADDR, 32'h01300);
        axw(REG_CMD, 32'h2);
        axw(REG_CMD, 32'h1);
        rchk(REG_STATUS, 32'h72, "sector change and read refused");
        axw(REG_STATUS, 32'h60);
        wst(ST_RUN, 1'b1);
        repeat (4) @(posedge aclk);
        chk({31'h0, sfp_flash_model_i.prog_active}, 32'h1, "program started");
        axw(REG_CMD, 32'h2);
        rchk(REG_STATUS, 32'h54, "load while running refused");
        axw(REG_STATUS, 32'h40);
        axw(REG_CMD, 32'h4);
        wst(ST_POLL_DONE, 1'b1);
        wst(ST_BUSY, 1'b0);
        rchk(REG_STATUS, 32'h18, "poll finished");
        chk({31'h0, sfp_flash_model_i.prog_active}, 32'h0, "poll ended early");
        fread(18'h01205, 8'hA5);
        fread(18'h01202, 8'h3C);
        fread(18'h012FF, 8'h81);
        rchk(REG_ADDR, 32'h012FF, "address register");
        summarize();
    end
endmodule : sfp_host_tb
